// [dv/pmd_partner_model.sv]
`timescale 1ns/100ps
module pmd_partner_model
	import lpi_pmd_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Requests from the block
	input  pmd_req_t  pmd_req,
	// Optical side
	input  wire logic mdi_rx_light,
	output logic      mdi_tx_light,
	// Toward the coding sublayer
	output logic      rx_to_pcs,
	output logic      signal_detect
);
	logic held_q, held_d;
	// Front end keeps its last state while off
	always_comb held_d = pmd_req.receive_front_end_request ? mdi_rx_light
		: held_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) held_q <= 1'b0;
		else held_q <= held_d;
	end
	assign mdi_tx_light = pmd_req.transmit_light_request;
	assign rx_to_pcs = pmd_req.receive_front_end_request ? mdi_rx_light
		: held_q;
	assign signal_detect = mdi_rx_light
		& ~pmd_req.signal_detect_suppress_request;
endmodule : pmd_partner_model

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	import lpi_pmd_pkg::*;
	logic     clk, resetn, loc_en, cap, link, sbs, lpi, p_quiet, rx_det;
	pmd_req_t req;
	tx_sym_t  sym;
	logic     lpe, light, rx_pcs, sd;
	int       n_errors, checks, cyc;
	lpi_pmd_power_control DUT (.clk(clk), .resetn(resetn),
		.local_lpi_enable(loc_en), .low_power_capability_flag(cap),
		.link_up(link), .sub_block_start(sbs), .lpi_assert(lpi),
		.partner_quiet(p_quiet), .rx_lpi_detect(rx_det), .pmd_req(req),
		.tx_symbol(sym), .low_power_enable(lpe));
	pmd_partner_model pm (.clk(clk), .resetn(resetn), .pmd_req(req),
		.mdi_rx_light(~p_quiet), .mdi_tx_light(light),
		.rx_to_pcs(rx_pcs), .signal_detect(sd));
	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [2:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic set_en(input logic l, c, k);
		@(posedge clk);
		loc_en <= l;
		cap <= c;
		link <= k;
	endtask : set_en
	task automatic pulse_start();
		@(posedge clk);
		sbs <= 1'b1;
		lpi <= 1'b1;
		@(posedge clk);
		sbs <= 1'b0;
	endtask : pulse_start
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		{resetn, loc_en, cap, link, sbs, lpi, p_quiet, rx_det} = 8'h00;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		step(1);
		check("reset req", 3'h6, req);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			set_en(i[2], i[1], i[0]);
			step(1);
			check("enable", {2'h0, i == 7}, lpe);
			step(1);
			check("suppress", {2'h0, i == 7}, req[0]);
		end
		$display("test enable done");
		for (int j = 0; j < 4; j++) begin
			@(posedge clk);
			p_quiet <= j[1];
			rx_det <= j[0];
			step(1);
			check("front end", {2'h0, j != 3}, req[1]);
			check("pmd rx", {2'h0, j < 2}, rx_pcs);
		end
		@(posedge clk);
		{p_quiet, rx_det} <= 2'h0;
		step(1);
		check("detect", 3'h0, sd);
		$display("test receive done");
		pulse_start();
		#1;
		check("lead", SYM_ZERO, sym);
		step(129);
		check("lead end", SYM_ZERO, sym);
		step(1);
		check("dark", SYM_DARK, sym);
		check("light off", 3'h0, light);
		step(7643);
		check("dark end", {1'h0, SYM_DARK}, {light, sym});
		step(1);
		check("trail", {1'h1, SYM_ZERO}, {light, sym});
		step(129);
		check("trail end", SYM_ZERO, sym);
		step(1);
		check("normal", SYM_DATA, sym);
		step(3);
		check("no start", SYM_DATA, sym);
		$display("test quiet slot done");
		set_en(1'b1, 1'b0, 1'b1);
		pulse_start();
		step(3);
		check("no cap", {1'h1, SYM_DATA}, {light, sym});
		$display("test no capability done");
		wrap_up();
	end
endmodule : tb_top

// [hw/lpi_pmd_map.svh]
`ifndef LPI_PMD_MAP_SVH
`define LPI_PMD_MAP_SVH

// Quiet sub-block layout, in symbols
`define LPI_ZERO_LEAD_SYMBOLS   13'd130
`define LPI_QUIET_SYMBOLS       13'd7644
`define LPI_ZERO_TRAIL_SYMBOLS  13'd130
`define LPI_COUNT_WIDTH         13

// Reset values of the three requests
`define LPI_TX_LIGHT_RESET      1'b1
`define LPI_RX_FRONT_RESET      1'b1
`define LPI_SD_SUPPRESS_RESET   1'b0

`endif

// [hw/lpi_pmd_pkg.sv]
package lpi_pmd_pkg;

	// Requests toward the medium-dependent sublayer
	typedef struct packed {
		logic transmit_light_request;
		logic receive_front_end_request;
		logic signal_detect_suppress_request;
	} pmd_req_t;

	// Transmit symbol content during a payload slot
	typedef enum logic [1:0] {
		SYM_DATA,
		SYM_ZERO,
		SYM_DARK
	} tx_sym_t;

	typedef enum {
		TX_NORMAL,
		TX_LEAD,
		TX_QUIET,
		TX_TRAIL
	} tx_state_t;

endpackage : lpi_pmd_pkg

// [hw/lpi_pmd_power_control.sv]
`timescale 1ns/100ps
`include "lpi_pmd_map.svh"

// How it works
// RULE_01: Drives transmit light, receive front end and signal detect suppress requests.
// RULE_02: Transmit light goes off in quiet, on for refresh and normal traffic.
// RULE_03: Receive request switches front end between active reception and low power.
// RULE_04: Receive request off only while partner is quiet, so front end keeps state.
// RULE_05: Signal detect suppress may assert only once the link is up.
// RULE_06: Low power enable is true only when both ends are capable and enabled.
// RULE_07: Transmit light on emits signal; off emits nothing.
// RULE_08: Receive request on passes signal; off ignores it and holds state.
// RULE_09: Transmit quiet begins and ends only at payload sub-block boundaries.
// RULE_10: Without partner capability the link never goes quiet.
// RULE_11: Quiet slot is 130 zeros, 7644 dark symbols, 130 zeros.
// RULE_12: After reset both power requests are on and suppress is off.
module lpi_pmd_power_control
	import lpi_pmd_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Capability exchange
	input  wire logic local_lpi_enable,
	input  wire logic low_power_capability_flag,
	input  wire logic link_up,
	// Transmit side, symbol clock domain
	input  wire logic sub_block_start,
	input  wire logic lpi_assert,
	// Receive side
	input  wire logic partner_quiet,
	input  wire logic rx_lpi_detect,
	// Outputs
	output pmd_req_t  pmd_req,
	output tx_sym_t   tx_symbol,
	output logic      low_power_enable
);

	localparam int CW = `LPI_COUNT_WIDTH;

	function automatic logic [CW-1:0] last_of(input logic [CW-1:0] n);
		return n - 13'd1;
	endfunction : last_of

	////////////////////////////////////////////////////////////////////
	// Enable
	logic en_q, en_d;

	always_comb begin
		en_d = local_lpi_enable & low_power_capability_flag & link_up; // RULE_06 RULE_10
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en_d;
		end
	end

	assign low_power_enable = en_q;

	////////////////////////////////////////////////////////////////////
	// Transmit quiet sequencer
	tx_state_t       st_q, st_d;
	logic [CW-1:0]   cnt_q, cnt_d;
	logic            tx_light_q, tx_light_d;
	tx_sym_t         sym_q, sym_d;

	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q + 13'd1;
		case (st_q)
			TX_NORMAL: begin
				cnt_d = '0;
				if (sub_block_start && en_q && lpi_assert) begin // RULE_09 RULE_10
					st_d = TX_LEAD;
				end
			end
			TX_LEAD: begin
				if (cnt_q == last_of(`LPI_ZERO_LEAD_SYMBOLS)) begin // RULE_11
					st_d  = TX_QUIET;
					cnt_d = '0;
				end
			end
			TX_QUIET: begin
				if (cnt_q == last_of(`LPI_QUIET_SYMBOLS)) begin // RULE_11
					st_d  = TX_TRAIL;
					cnt_d = '0;
				end
			end
			TX_TRAIL: begin
				if (cnt_q == last_of(`LPI_ZERO_TRAIL_SYMBOLS)) begin // RULE_11
					st_d  = TX_NORMAL;
					cnt_d = '0;
				end
			end
			default: begin
				st_d  = TX_NORMAL;
				cnt_d = '0;
			end
		endcase
		tx_light_d = (st_d != TX_QUIET); // RULE_02 RULE_07
		case (st_d)
			TX_LEAD:  sym_d = SYM_ZERO;
			TX_TRAIL: sym_d = SYM_ZERO;
			TX_QUIET: sym_d = SYM_DARK;
			default:  sym_d = SYM_DATA;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q       <= TX_NORMAL;
			cnt_q      <= '0;
			tx_light_q <= `LPI_TX_LIGHT_RESET; // RULE_12
			sym_q      <= SYM_DATA;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			tx_light_q <= tx_light_d;
			sym_q      <= sym_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive front end and signal detect
	logic rx_front_q, rx_front_d;
	logic sd_sup_q, sd_sup_d;

	always_comb begin
		rx_front_d = !(en_q && rx_lpi_detect && partner_quiet); // RULE_03 RULE_04 RULE_08
		sd_sup_d   = en_q; // RULE_05
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_front_q <= `LPI_RX_FRONT_RESET; // RULE_12
			sd_sup_q   <= `LPI_SD_SUPPRESS_RESET; // RULE_12
		end else begin
			rx_front_q <= rx_front_d;
			sd_sup_q   <= sd_sup_d;
		end
	end

	always_comb begin
		pmd_req.transmit_light_request         = tx_light_q; // RULE_01
		pmd_req.receive_front_end_request      = rx_front_q;
		pmd_req.signal_detect_suppress_request = sd_sup_q;
	end

	assign tx_symbol = sym_q;

	////////////////////////////////////////////////////////////////////
	// Run length of the current sequencer state, for the checks
	tx_state_t       chk_st_q, chk_st_d;
	logic [CW-1:0]   run_q, run_d;

	always_comb begin
		chk_st_d = st_q;
		run_d    = (st_q != chk_st_q) ? 13'd1 : run_q + 13'd1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chk_st_q <= TX_NORMAL;
			run_q    <= '0;
		end else begin
			chk_st_q <= chk_st_d;
			run_q    <= run_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_enable_and;
		@(posedge clk) disable iff (!resetn)
		low_power_enable == $past(local_lpi_enable
			& low_power_capability_flag & link_up);
	endproperty
	a_enable_and: assert property (p_enable_and) // RULE_06
		else $error("Enable does not follow capability");

	property p_no_quiet_without_cap;
		@(posedge clk) disable iff (!resetn)
		!low_power_enable |=> (st_q != TX_LEAD) || $past(st_q) == TX_LEAD;
	endproperty
	a_no_quiet_without_cap: assert property (p_no_quiet_without_cap) // RULE_10
		else $error("Quiet entered without capability");

	property p_enter_on_boundary;
		@(posedge clk) disable iff (!resetn)
		$rose(st_q == TX_LEAD) |-> $past(sub_block_start);
	endproperty
	a_enter_on_boundary: assert property (p_enter_on_boundary) // RULE_09
		else $error("Quiet entry off boundary");

	property p_lead_len;
		@(posedge clk) disable iff (!resetn)
		(st_q != chk_st_q) && (chk_st_q == TX_LEAD) |->
			(run_q == `LPI_ZERO_LEAD_SYMBOLS) && (st_q == TX_QUIET);
	endproperty
	a_lead_len: assert property (p_lead_len) // RULE_11
		else $error("Lead zero run wrong length");

	property p_trail_len;
		@(posedge clk) disable iff (!resetn)
		(st_q != chk_st_q) && (chk_st_q == TX_TRAIL) |->
			(run_q == `LPI_ZERO_TRAIL_SYMBOLS) && (st_q == TX_NORMAL);
	endproperty
	a_trail_len: assert property (p_trail_len) // RULE_11
		else $error("Trail zero run wrong length");

	property p_quiet_len;
		@(posedge clk) disable iff (!resetn)
		(st_q != chk_st_q) && (chk_st_q == TX_QUIET) |->
			(run_q == `LPI_QUIET_SYMBOLS) && (st_q == TX_TRAIL);
	endproperty
	a_quiet_len: assert property (p_quiet_len) // RULE_11
		else $error("Quiet period wrong length");

	property p_slot_bounded;
		@(posedge clk) disable iff (!resetn)
		(st_q != TX_NORMAL) && (st_q == chk_st_q) |->
			run_q < `LPI_QUIET_SYMBOLS;
	endproperty
	a_slot_bounded: assert property (p_slot_bounded) // RULE_11
		else $error("Quiet slot state overstays");

	property p_light_dark;
		@(posedge clk) disable iff (!resetn)
		!pmd_req.transmit_light_request == (tx_symbol == SYM_DARK);
	endproperty
	a_light_dark: assert property (p_light_dark) // RULE_02
		else $error("Light request and dark symbol disagree");

	property p_sd_link;
		@(posedge clk) disable iff (!resetn)
		pmd_req.signal_detect_suppress_request |-> $past(link_up, 2);
	endproperty
	a_sd_link: assert property (p_sd_link) // RULE_05
		else $error("Suppress without link");

	property p_rx_off_quiet;
		@(posedge clk) disable iff (!resetn)
		!pmd_req.receive_front_end_request |-> $past(partner_quiet)
			&& $past(low_power_enable);
	endproperty
	a_rx_off_quiet: assert property (p_rx_off_quiet) // RULE_04
		else $error("Front end off outside partner quiet");

	c_quiet: cover property (@(posedge clk) disable iff (!resetn)
		$rose(st_q == TX_QUIET));
	c_full_cycle: cover property (@(posedge clk) disable iff (!resetn)
		$rose(st_q == TX_NORMAL));
	c_rx_off: cover property (@(posedge clk) disable iff (!resetn)
		$fell(pmd_req.receive_front_end_request));
	c_sd: cover property (@(posedge clk) disable iff (!resetn)
		$rose(pmd_req.signal_detect_suppress_request));

endmodule : lpi_pmd_power_control
